// ### hw/ubsp_status_pins.sv
module ubsp_status_pins
  import ubsp_pkg::*;
#(
  parameter int HEARTBEAT_CYCLES = HEARTBEAT_CYC,
  parameter int ACT_HOLD_CYCLES = ACT_HOLD_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bridge status and host pin control
  input wire ubsp_status_t status,
  input wire ubsp_pinctl_t spareCtlA,
  input wire ubsp_pinctl_t spareCtlB,
  input wire ubsp_pinctl_t spareCtlC,
  input wire ubsp_pinctl_t powerCtl0,
  input wire ubsp_pinctl_t powerCtl1,
  // Spare pins (oe low drives)
  input wire logic spareAIn,
  output logic spareAOut,
  output logic spareAOe,
  output logic spareAPullUp,
  input wire logic spareBIn,
  output logic spareBOut,
  output logic spareBOe,
  input wire logic spareCIn,
  output logic spareCOut,
  output logic spareCOe,
  output logic spareCPullUp,
  // Link power state pins
  output logic [1:0] linkPowerOut,
  output logic [1:0] linkPowerOe,
  // Indicators (oe low drives)
  output logic hsSuspendOut,
  output logic hsSuspendOe,
  output logic superspeedOut,
  output logic superspeedOe,
  output logic diskActivityOut,
  output logic diskActivityOe,
  output logic heartbeatOut,
  output logic heartbeatOe,
  // Board inputs
  input wire logic wakeButtonIn,
  input wire logic selfPoweredStrap,
  input wire logic powerFaultNIn,
  // Decoded status to firmware
  output logic remoteWakeReq,
  output logic selfPowered,
  output logic powerFault,
  output logic [2:0] spareInLevel
);
  logic wakeSync;
  logic faultNSync;
  logic wakePrev;
  logic active;
  logic [31:0] hbCount;
  logic [31:0] actCount;

  // ******************************
  // Input synchronisers
  // ******************************
  ubsp_sync uWake (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(wakeButtonIn),
    .rstVal(1'b0),
    .dout(wakeSync)
  );
  ubsp_sync uFault (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(powerFaultNIn),
    .rstVal(1'b1),
    .dout(faultNSync)
  );

  assign active = status.fwRunning;

  // ******************************
  // Board input decode
  // ******************************
  // Edge detect so a held button asks once
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wakePrev <= 1'b0;
      remoteWakeReq <= 1'b0;
      selfPowered <= 1'b0;
      powerFault <= 1'b0;
      spareInLevel <= 3'h0;
    end else begin
      wakePrev <= wakeSync;
      remoteWakeReq <= active && wakeSync && !wakePrev;
      selfPowered <= selfPoweredStrap;
      powerFault <= !faultNSync;
      spareInLevel <= {spareCIn, spareBIn, spareAIn};
    end
  end

  // ******************************
  // Spare pins
  // ******************************
  // Pull direction is fixed; only drive changes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      spareAOe <= 1'b1;
      spareAOut <= 1'b0;
      spareAPullUp <= 1'b0;
      spareBOe <= 1'b1;
      spareBOut <= 1'b0;
      spareCOe <= 1'b1;
      spareCOut <= 1'b0;
      spareCPullUp <= 1'b1;
    end else begin
      spareAOe <= !(active && spareCtlA.asOutput);
      spareAOut <= spareCtlA.level;
      spareBOe <= !(active && spareCtlB.asOutput);
      spareBOut <= spareCtlB.level;
      spareCOe <= !(active && spareCtlC.asOutput);
      spareCOut <= spareCtlC.level;
    end
  end

  // ******************************
  // Link power state pins
  // ******************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      linkPowerOut <= LPS_U3;
      linkPowerOe <= 2'h3;
    end else if (active && status.u12Enabled) begin
      linkPowerOe <= 2'h0;
      case (status.linkState)
        UBSP_ST_U0: linkPowerOut <= LPS_U0;
        UBSP_ST_U1: linkPowerOut <= LPS_U1;
        UBSP_ST_U2: linkPowerOut <= LPS_U2;
        default: linkPowerOut <= LPS_U3;
      endcase
    end else begin
      linkPowerOe <= {!(active && powerCtl1.asOutput), !(active && powerCtl0.asOutput)};
      linkPowerOut <= {powerCtl1.level, powerCtl0.level};
    end
  end

  // ******************************
  // USB indicators
  // ******************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hsSuspendOut <= 1'b0;
      hsSuspendOe <= 1'b1;
      superspeedOut <= 1'b0;
      superspeedOe <= 1'b1;
    end else begin
      hsSuspendOe <= !active;
      hsSuspendOut <= status.usb2Attached && status.usb2Suspended;
      superspeedOe <= !active;
      superspeedOut <= status.ssConnected;
    end
  end

  // ******************************
  // Disk activity and heartbeat
  // ******************************
  // Stretch transfers so short bursts are visible
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      actCount <= 32'h0;
      diskActivityOut <= 1'b0;
      diskActivityOe <= 1'b1;
    end else begin
      diskActivityOe <= !active;
      if (status.diskXfer) begin
        actCount <= 32'(ACT_HOLD_CYCLES);
      end else if (actCount != 32'h0) begin
        actCount <= actCount - 32'h1;
      end
      diskActivityOut <= active && (status.diskXfer || actCount != 32'h0);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hbCount <= 32'h0;
      heartbeatOut <= 1'b0;
      heartbeatOe <= 1'b1;
    end else begin
      heartbeatOe <= !active;
      if (!active) begin
        hbCount <= 32'h0;
      end else if (hbCount >= 32'(HEARTBEAT_CYCLES - 1)) begin
        hbCount <= 32'h0;
        heartbeatOut <= !heartbeatOut;
      end else begin
        hbCount <= hbCount + 32'h1;
      end
    end
  end

  // ******************************
  // Assertions
  // ******************************
  // Button low, then held high long enough to cross the synchroniser
  sequence s_press;
    !wakeButtonIn ##1 wakeButtonIn [*3] ##0 active;
  endsequence
  property p_wake;
    @(posedge sys_clk) disable iff (rst) s_press |=> remoteWakeReq;
  endproperty
  a_wake: assert property (p_wake) else $error("wake request missing");
  // Pin level must survive two sync flops and the output flop
  sequence s_fault_low;
    !powerFaultNIn [*3];
  endsequence
  sequence s_supply_ok;
    powerFaultNIn [*3];
  endsequence
  property p_fault;
    @(posedge sys_clk) disable iff (rst) s_fault_low |=> powerFault;
  endproperty
  a_fault: assert property (p_fault) else $error("power fault missed");
  property p_strap;
    @(posedge sys_clk) disable iff (rst) 1'b1 |=> selfPowered == $past(selfPoweredStrap);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not followed");
  // Indicator follows the connection one edge later
  property p_ss;
    @(posedge sys_clk) disable iff (rst) active
      |=> superspeedOut == $past(status.ssConnected) && !superspeedOe;
  endproperty
  a_ss: assert property (p_ss) else $error("superspeed indicator wrong");
  property p_susp;
    @(posedge sys_clk) disable iff (rst)
      status.usb2Attached && status.usb2Suspended |=> hsSuspendOut;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend indicator low");
  property p_lps;
    @(posedge sys_clk) disable iff (rst) active && status.u12Enabled
      |=> linkPowerOe == 2'h0 && linkPowerOut == $past(status.linkState);
  endproperty
  a_lps: assert property (p_lps) else $error("power code wrong");
  property p_spare;
    @(posedge sys_clk) disable iff (rst) !active |=> spareAOe && spareBOe && spareCOe;
  endproperty
  a_spare: assert property (p_spare) else $error("spare pin driven early");
  property p_idle;
    @(posedge sys_clk) disable iff (rst) !active |=> heartbeatOe && diskActivityOe;
  endproperty
  a_idle: assert property (p_idle) else $error("indicator driven before firmware");
  property p_act;
    @(posedge sys_clk) disable iff (rst) active && status.diskXfer |=> diskActivityOut;
  endproperty
  a_act: assert property (p_act) else $error("disk activity missing");
  // A held button must not repeat the request
  property p_wake_pulse;
    @(posedge sys_clk) disable iff (rst) remoteWakeReq |=> !remoteWakeReq;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake request stuck");
  // No wake request before firmware runs
  property p_wake_gate;
    @(posedge sys_clk) disable iff (rst) !active |=> !remoteWakeReq;
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake request too early");
  // Healthy supply clears the fault flag
  property p_fault_clear;
    @(posedge sys_clk) disable iff (rst) s_supply_ok |=> !powerFault;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("false power fault");
  // Pull directions are fixed at their reset values
  property p_pulls;
    @(posedge sys_clk) disable iff (rst) 1'b1 |-> !spareAPullUp && spareCPullUp;
  endproperty
  a_pulls: assert property (p_pulls) else $error("spare pull direction wrong");
  // Host owns the power pins when low power states are off
  property p_lps_host;
    @(posedge sys_clk) disable iff (rst) active && !status.u12Enabled
      |=> linkPowerOe == {!$past(powerCtl1.asOutput), !$past(powerCtl0.asOutput)};
  endproperty
  a_lps_host: assert property (p_lps_host) else $error("power pin drive wrong");
  // Heartbeat frozen while firmware is down
  property p_hb_idle;
    @(posedge sys_clk) disable iff (rst) !active |=> $stable(heartbeatOut);
  endproperty
  a_hb_idle: assert property (p_hb_idle) else $error("heartbeat without firmware");
endmodule

// ### hw/ubsp_pkg.sv
package ubsp_pkg;
  // ******************************
  // Link power codes
  // ******************************
  localparam logic [1:0] LPS_U3 = 2'h0;
  localparam logic [1:0] LPS_U2 = 2'h1;
  localparam logic [1:0] LPS_U1 = 2'h2;
  localparam logic [1:0] LPS_U0 = 2'h3;

  // ******************************
  // Timing
  // ******************************
  localparam int CLK_MHZ = 250;
  localparam int HEARTBEAT_MS = 500;
  localparam int HEARTBEAT_CYC = HEARTBEAT_MS * 1000 * CLK_MHZ;
  localparam int ACT_HOLD_MS = 50;
  localparam int ACT_HOLD_CYC = ACT_HOLD_MS * 1000 * CLK_MHZ;

  // Link state from the USB core
  typedef enum logic [1:0] {
    UBSP_ST_U3 = 2'b00,
    UBSP_ST_U2 = 2'b01,
    UBSP_ST_U1 = 2'b10,
    UBSP_ST_U0 = 2'b11
  } ubsp_lstate_t;

  // Host control of one spare pin or link power pin
  typedef struct packed {
    logic asOutput;
    logic level;
  } ubsp_pinctl_t;

  // Bridge status from the firmware side
  typedef struct packed {
    logic fwRunning;
    logic u12Enabled;
    ubsp_lstate_t linkState;
    logic usb2Attached;
    logic usb2Suspended;
    logic ssConnected;
    logic diskXfer;
  } ubsp_status_t;
endpackage

// ### hw/ubsp_sync.sv
module ubsp_sync
  import ubsp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Data
  input wire logic din,
  input wire logic rstVal,
  output logic dout
);
  logic meta;

  // ******************************
  // Two flop synchroniser
  // ******************************
  always_ff @(posedge sys_clk) begin
    // Reset to the pin's idle level, so no false event follows reset
    if (rst) begin
      meta <= rstVal;
      dout <= rstVal;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// ### tb/ubsp_board_model.sv
module ubsp_board_model
  import ubsp_pkg::*;
(
  // Bridge pin drives
  input wire logic spareAOut,
  input wire logic spareAOe,
  input wire logic spareAPullUp,
  input wire logic spareBOut,
  input wire logic spareBOe,
  input wire logic spareCOut,
  input wire logic spareCOe,
  input wire logic spareCPullUp,
  // Bench controls
  input wire logic pressBtn,
  input wire logic faultOn,
  input wire logic selfPow,
  // Board levels
  output logic spareAIn,
  output logic spareBIn,
  output logic spareCIn,
  output logic wakeButtonIn,
  output logic selfPoweredStrap,
  output logic powerFaultNIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pins fall to the pull level, never keep the last value
  assign spareAIn = !spareAOe ? spareAOut : spareAPullUp;
  assign spareBIn = !spareBOe ? spareBOut : 1'b0;
  assign spareCIn = !spareCOe ? spareCOut : spareCPullUp;
  // Open button reads low, healthy supply reads high
  assign wakeButtonIn = pressBtn;
  assign powerFaultNIn = !faultOn;
  assign selfPoweredStrap = selfPow;
endmodule

// ### tb/testbench.sv
module testbench
  import ubsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HB = 8;
  localparam int ACT = 4;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  ubsp_status_t status = '0;
  ubsp_pinctl_t spareCtlA = '0, spareCtlB = '0, spareCtlC = '0;
  ubsp_pinctl_t powerCtl0 = '0, powerCtl1 = '0;
  logic pressBtn = 1'b0, faultOn = 1'b0, selfPow = 1'b0, hbPrev;
  logic spareAIn, spareAOut, spareAOe, spareAPullUp, spareBIn, spareBOut, spareBOe;
  logic spareCIn, spareCOut, spareCOe, spareCPullUp, hsSuspendOut, hsSuspendOe;
  logic [1:0] linkPowerOut, linkPowerOe;
  logic superspeedOut, superspeedOe, diskActivityOut, diskActivityOe;
  logic heartbeatOut, heartbeatOe, wakeButtonIn, selfPoweredStrap, powerFaultNIn;
  logic remoteWakeReq, selfPowered, powerFault;
  logic [2:0] spareInLevel;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  ubsp_status_pins #(.HEARTBEAT_CYCLES(HB), .ACT_HOLD_CYCLES(ACT)) dut_u (
    .sys_clk, .rst, .status, .spareCtlA, .spareCtlB, .spareCtlC, .powerCtl0,
    .powerCtl1, .spareAIn, .spareAOut, .spareAOe, .spareAPullUp, .spareBIn,
    .spareBOut, .spareBOe, .spareCIn, .spareCOut, .spareCOe, .spareCPullUp,
    .linkPowerOut, .linkPowerOe, .hsSuspendOut, .hsSuspendOe, .superspeedOut,
    .superspeedOe, .diskActivityOut, .diskActivityOe, .heartbeatOut, .heartbeatOe,
    .wakeButtonIn, .selfPoweredStrap, .powerFaultNIn, .remoteWakeReq,
    .selfPowered, .powerFault, .spareInLevel);
  ubsp_board_model board_u (.spareAOut, .spareAOe, .spareAPullUp, .spareBOut,
    .spareBOe, .spareCOut, .spareCOe, .spareCPullUp, .pressBtn, .faultOn,
    .selfPow, .spareAIn, .spareBIn, .spareCIn, .wakeButtonIn,
    .selfPoweredStrap, .powerFaultNIn);
  // 250 MHz core clock, toggled directly every 2 ns
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // Sample 1 ns after an edge so its updates have landed
  task automatic wt(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog, run needs about 90 cycles
  initial begin
    #20us;
    num_errors++;
    close_out();
  end
  // Main sequence
  initial begin
    wt(9);
    chk({spareAOe, spareBOe, spareCOe, hsSuspendOe, superspeedOe, diskActivityOe,
      heartbeatOe, 1'b1}, 8'hff);
    chk({4'h0, linkPowerOe, spareAPullUp, spareCPullUp}, 8'h0d);
    @(posedge sys_clk);
    // Reset hold scaled down from milliseconds to ten cycles
    rst <= 1'b0;
    status.ssConnected <= 1'b1;
    status.usb2Attached <= 1'b1;
    status.usb2Suspended <= 1'b1;
    wt(1);
    chk({6'h0, powerFault, remoteWakeReq}, 8'h00);
    wt(2);
    chk({6'h0, superspeedOe, hsSuspendOe}, 8'h03);
    @(posedge sys_clk);
    status.fwRunning <= 1'b1;
    wt(1);
    chk({4'h0, superspeedOut, superspeedOe, hsSuspendOut, hsSuspendOe}, 8'h0a);
    @(posedge sys_clk);
    status.ssConnected <= 1'b0;
    status.usb2Suspended <= 1'b0;
    wt(1);
    chk({6'h0, superspeedOut, hsSuspendOut}, 8'h00);
    // Every link state code, U3 first
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      status.u12Enabled <= 1'b1;
      status.linkState <= ubsp_lstate_t'(i);
      wt(1);
      chk({4'h0, linkPowerOut, linkPowerOe}, 8'(i * 4));
    end
    @(posedge sys_clk);
    status.u12Enabled <= 1'b0;
    powerCtl0 <= 2'b11;
    powerCtl1 <= 2'b10;
    spareCtlA <= 2'b11;
    spareCtlB <= 2'b10;
    spareCtlC <= 2'b10;
    wt(2);
    chk({4'h0, linkPowerOut, linkPowerOe}, 8'h04);
    chk({2'h0, spareAOe, spareBOe, spareCOe, spareInLevel}, 8'h01);
    @(posedge sys_clk);
    spareCtlA <= 2'b00;
    spareCtlB <= 2'b00;
    spareCtlC <= 2'b00;
    selfPow <= 1'b1;
    faultOn <= 1'b1;
    pressBtn <= 1'b1;
    n = 0;
    repeat (8) begin
      wt(1);
      n += (remoteWakeReq === 1'b1);
    end
    chk(8'(n), 8'h01);
    chk({2'h0, spareAOe, spareBOe, spareCOe, spareInLevel}, 8'h3c);
    chk({6'h0, selfPowered, powerFault}, 8'h03);
    @(posedge sys_clk);
    pressBtn <= 1'b0;
    selfPow <= 1'b0;
    faultOn <= 1'b0;
    status.diskXfer <= 1'b1;
    wt(1);
    chk({6'h0, diskActivityOut, diskActivityOe}, 8'h02);
    @(posedge sys_clk);
    status.diskXfer <= 1'b0;
    wt(3);
    chk({6'h0, selfPowered, powerFault}, 8'h00);
    chk({7'h0, diskActivityOut}, 8'h01);
    wt(ACT + 2);
    chk({7'h0, diskActivityOut}, 8'h00);
    // Heartbeat toggles once per period
    hbPrev = heartbeatOut;
    n = 0;
    repeat (4 * HB) begin
      wt(1);
      n += (heartbeatOut !== hbPrev);
      hbPrev = heartbeatOut;
    end
    chk(8'(n), 8'h04);
    chk({7'h0, heartbeatOe}, 8'h00);
    // Mid-run reset drops every spare and indicator drive, then no false fault
    @(posedge sys_clk);
    rst <= 1'b1;
    wt(2);
    chk({spareAOe, spareBOe, spareCOe, hsSuspendOe, superspeedOe, diskActivityOe,
      heartbeatOe, 1'b1}, 8'hff);
    @(posedge sys_clk);
    rst <= 1'b0;
    wt(1);
    chk({6'h0, powerFault, remoteWakeReq}, 8'h00);
    close_out();
  end
endmodule
